// *** inc/exc_pkg.sv ***
// Constants and types shared by the exception vector sequencer.
package exc_pkg;

    // Bus and vector widths.
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int VEC_W  = 8;

    // Status word field positions.
    localparam int STAT_TRACE_BIT = 15;
    localparam int STAT_SUPER_BIT = 13;
    localparam int STAT_MASK_HI   = 10;
    localparam int STAT_MASK_LO   = 8;

    // Status word after reset: supervisor, no trace, mask at level 7.
    localparam logic [15:0] RESET_STATUS_WORD = 16'h2700;

    // Internally generated vector numbers.
    localparam logic [7:0] VEC_RESET         = 8'h00;
    localparam logic [7:0] VEC_BUS_ERROR     = 8'h02;
    localparam logic [7:0] VEC_ADDRESS_ERROR = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL       = 8'h04;
    localparam logic [7:0] VEC_DIVIDE_ZERO   = 8'h05;
    localparam logic [7:0] VEC_BOUND_CHECK   = 8'h06;
    localparam logic [7:0] VEC_OVERFLOW_TRAP = 8'h07;
    localparam logic [7:0] VEC_PRIVILEGE     = 8'h08;
    localparam logic [7:0] VEC_TRACE         = 8'h09;
    localparam logic [7:0] VEC_LINE_A        = 8'h0a;
    localparam logic [7:0] VEC_LINE_F        = 8'h0b;
    localparam logic [7:0] VEC_SPURIOUS      = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE     = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE     = 8'h20;

    // Opcode top nibbles that select the emulator vectors.
    localparam logic [3:0] LINE_A_NIBBLE = 4'ha;
    localparam logic [3:0] LINE_F_NIBBLE = 4'hf;

    // Vector table geometry and sequencing counts.
    localparam int          VEC_SHIFT        = 2;
    localparam int          VEC_TABLE_BYTES  = 1024;
    localparam logic [1:0]  VEC_LAST_WORD    = 2'h1;
    localparam logic [1:0]  RESET_LAST_WORD  = 2'h3;
    localparam logic [1:0]  FRAME_LAST_WORD  = 2'h2;
    localparam logic [31:0] STACK_STEP       = 32'h2;
    localparam logic [19:0] IACK_ADDR_HI     = 20'hfffff;

    // Exception causes presented by the core.
    typedef enum logic [3:0] {
        cause_reset,
        cause_bus_error,
        cause_address_error,
        cause_illegal_opcode,
        cause_divide_zero,
        cause_bound_check_instruction,
        cause_overflow_trap_instruction,
        cause_privilege,
        cause_trace,
        cause_interrupt,
        cause_trap
    } cause_t;

    // Address spaces of a bus cycle.
    typedef enum logic [1:0] {
        supervisor_data_space,
        supervisor_program_space,
        cpu_space
    } space_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        st_idle,
        st_iack,
        st_stack,
        st_fetch
    } state_t;

    // One bus cycle request.
    typedef struct packed {
        logic              req;
        logic              write;
        space_t            space;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_cmd_t;

endpackage

// *** core/exception_vector_sequencer.sv ***
// Exception entry sequencer: status update, vector number, stacking, fetch.
`timescale 1ns/100ps

module exception_vector_sequencer
    import exc_pkg::*;
(
    input  wire logic              i_clk,            // Processor clock.
    input  wire logic              i_reset,          // Sync reset, high.
    input  wire logic              i_exc_req,        // Start exception.
    input  wire cause_t            i_exc_cause,      // Exception cause.
    input  wire logic [15:0]       i_opcode,         // Offending opcode.
    input  wire logic [3:0]        i_trap_num,       // Trap operand n.
    input  wire logic [2:0]        i_interrupt_level_inputs, // Level.
    input  wire logic [15:0]       i_status_word,    // Current status.
    input  wire logic [31:0]       i_pc,             // Return address.
    input  wire logic [31:0]       i_supervisor_stack_pointer, // Stack.
    input  wire logic              i_bus_ack,        // Cycle done.
    input  wire logic              i_bus_err,        // Cycle bus error.
    input  wire logic              i_bus_autovector, // Autovector ask.
    input  wire logic [DATA_W-1:0] i_bus_rdata,      // Read data.
    output bus_cmd_t               o_bus,            // Bus cycle request.
    output logic                   o_busy,           // Sequence running.
    output logic                   o_done,           // Handler ready.
    output logic [31:0]            o_pc,             // Handler address.
    output logic [31:0]            o_supervisor_stack_pointer, // New stack.
    output logic [15:0]            o_status_word,    // New status word.
    output logic [15:0]            o_saved_status_word, // Copy taken.
    output logic [VEC_W-1:0]       o_vector_num      // Vector used.
);

    // Whole sequencer state in one record.
    typedef struct packed {
        state_t      state;
        cause_t      cause;
        logic [1:0]  word;
        logic [2:0]  level;
        logic [7:0]  vec;
        logic [15:0] saved_stat;
        logic [15:0] stat;
        logic [31:0] pc;
        logic [31:0] stk_ptr;
        bus_cmd_t    bus;
        logic        busy;
        logic        done;
    } seq_state_t;

    seq_state_t s_ff;
    seq_state_t nxt_s;

    // Vector number that internal logic supplies for a non-interrupt cause.
    function automatic logic [7:0] internal_vector(
        input cause_t     cause,
        input logic [15:0] opcode,
        input logic [3:0] trap_num
    );
        logic [7:0] v;
        v = VEC_ILLEGAL;
        case (cause)
            cause_reset:                     v = VEC_RESET;
            cause_bus_error:                 v = VEC_BUS_ERROR;
            cause_address_error:             v = VEC_ADDRESS_ERROR;
            cause_divide_zero:               v = VEC_DIVIDE_ZERO;
            cause_bound_check_instruction:   v = VEC_BOUND_CHECK;
            cause_overflow_trap_instruction: v = VEC_OVERFLOW_TRAP;
            cause_privilege:                 v = VEC_PRIVILEGE;
            cause_trace:                     v = VEC_TRACE;
            cause_trap:                      v = VEC_TRAP_BASE
                                                 + {4'h0, trap_num};
            cause_illegal_opcode: begin
                if (opcode[15:12] == LINE_A_NIBBLE) begin
                    v = VEC_LINE_A;
                end else if (opcode[15:12] == LINE_F_NIBBLE) begin
                    v = VEC_LINE_F;
                end else begin
                    v = VEC_ILLEGAL;
                end
            end
            default:                         v = VEC_ILLEGAL;
        endcase
        return v;
    endfunction

    // Bus address of one word of a vector, cut to the bus width.
    function automatic logic [ADDR_W-1:0] vector_word_addr(
        input logic [7:0] vec,
        input logic [1:0] word
    );
        logic [31:0] offset;
        offset = {22'h0, vec, 2'h0};
        offset = offset + {29'h0, word, 1'h0};
        return offset[ADDR_W-1:0];
    endfunction

    // Next-state logic of the whole sequence.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        case (s_ff.state)
            st_idle: begin
                if (i_exc_req) begin
                    nxt_s.cause = i_exc_cause;
                    nxt_s.saved_stat = i_status_word;
                    nxt_s.stat = i_status_word;
                    nxt_s.stat[STAT_SUPER_BIT] = 1'b1;
                    nxt_s.stat[STAT_TRACE_BIT] = 1'b0;
                    nxt_s.level = i_interrupt_level_inputs;
                    nxt_s.pc = i_pc;
                    nxt_s.stk_ptr = i_supervisor_stack_pointer;
                    nxt_s.word = 2'h0;
                    nxt_s.vec = internal_vector(i_exc_cause, i_opcode,
                                                i_trap_num);
                    if (i_exc_cause == cause_interrupt) begin
                        nxt_s.stat[STAT_MASK_HI:STAT_MASK_LO] =
                            i_interrupt_level_inputs;
                        nxt_s.state = st_iack;
                    end else if (i_exc_cause == cause_reset) begin
                        nxt_s.stat = RESET_STATUS_WORD;
                        nxt_s.state = st_fetch;
                    end else begin
                        nxt_s.state = st_stack;
                    end
                end
            end
            st_iack: begin
                if (!s_ff.bus.req) begin
                    // Acknowledge cycle shows the level on the address bus.
                    nxt_s.bus.req = 1'b1;
                    nxt_s.bus.write = 1'b0;
                    nxt_s.bus.space = cpu_space;
                    nxt_s.bus.addr = {IACK_ADDR_HI, s_ff.level, 1'h1};
                    nxt_s.bus.wdata = '0;
                end else if (i_bus_err) begin
                    nxt_s.bus.req = 1'b0;
                    nxt_s.vec = VEC_SPURIOUS;
                    nxt_s.state = st_stack;
                end else if (i_bus_ack) begin
                    nxt_s.bus.req = 1'b0;
                    if (i_bus_autovector) begin
                        nxt_s.vec = VEC_AUTO_BASE
                                    + {5'h0, s_ff.level};
                    end else begin
                        nxt_s.vec = i_bus_rdata[7:0];
                    end
                    nxt_s.state = st_stack;
                end
            end
            st_stack: begin
                if (!s_ff.bus.req) begin
                    // Predecrement, then write: counter low, high, status.
                    nxt_s.stk_ptr = s_ff.stk_ptr - STACK_STEP;
                    nxt_s.bus.req = 1'b1;
                    nxt_s.bus.write = 1'b1;
                    nxt_s.bus.space = supervisor_data_space;
                    nxt_s.bus.addr = nxt_s.stk_ptr[ADDR_W-1:0];
                    case (s_ff.word)
                        2'h0:    nxt_s.bus.wdata = s_ff.pc[15:0];
                        2'h1:    nxt_s.bus.wdata = s_ff.pc[31:16];
                        default: nxt_s.bus.wdata = s_ff.saved_stat;
                    endcase
                end else if (i_bus_ack || i_bus_err) begin
                    nxt_s.bus.req = 1'b0;
                    if (s_ff.word == FRAME_LAST_WORD) begin
                        nxt_s.word = 2'h0;
                        nxt_s.state = st_fetch;
                    end else begin
                        nxt_s.word = s_ff.word + 2'h1;
                    end
                end
            end
            st_fetch: begin
                if (!s_ff.bus.req) begin
                    nxt_s.bus.req = 1'b1;
                    nxt_s.bus.write = 1'b0;
                    nxt_s.bus.wdata = '0;
                    nxt_s.bus.addr = vector_word_addr(s_ff.vec, s_ff.word);
                    if (s_ff.cause == cause_reset) begin
                        nxt_s.bus.space = supervisor_program_space;
                    end else begin
                        nxt_s.bus.space = supervisor_data_space;
                    end
                end else if (i_bus_ack || i_bus_err) begin
                    nxt_s.bus.req = 1'b0;
                    // Even words are high halves, odd words low halves.
                    if (s_ff.cause == cause_reset && !s_ff.word[1]) begin
                        if (!s_ff.word[0]) begin
                            nxt_s.stk_ptr[31:16] = i_bus_rdata;
                        end else begin
                            nxt_s.stk_ptr[15:0] = i_bus_rdata;
                        end
                    end else if (!s_ff.word[0]) begin
                        nxt_s.pc[31:16] = i_bus_rdata;
                    end else begin
                        nxt_s.pc[15:0] = i_bus_rdata;
                    end
                    if ((s_ff.cause == cause_reset
                         && s_ff.word == RESET_LAST_WORD)
                        || (s_ff.cause != cause_reset
                         && s_ff.word == VEC_LAST_WORD)) begin
                        nxt_s.word = 2'h0;
                        nxt_s.done = 1'b1;
                        nxt_s.state = st_idle;
                    end else begin
                        nxt_s.word = s_ff.word + 2'h1;
                    end
                end
            end
            default: begin
                nxt_s.state = st_idle;
                nxt_s.bus.req = 1'b0;
            end
        endcase
        nxt_s.busy = (nxt_s.state != st_idle);
    end

    // State register; reset starts the reset vector fetch at once.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_ff <= '0;
            s_ff.state <= st_fetch;
            s_ff.cause <= cause_reset;
            s_ff.vec <= VEC_RESET;
            s_ff.stat <= RESET_STATUS_WORD;
            s_ff.bus.space <= supervisor_program_space;
            s_ff.busy <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs come straight from the state register.
    assign o_bus = s_ff.bus;
    assign o_busy = s_ff.busy;
    assign o_done = s_ff.done;
    assign o_pc = s_ff.pc;
    assign o_supervisor_stack_pointer = s_ff.stk_ptr;
    assign o_status_word = s_ff.stat;
    assign o_saved_status_word = s_ff.saved_stat;
    assign o_vector_num = s_ff.vec;

endmodule

// *** testbench/seq_monitor.sv ***
// Port checker for the exception vector sequencer.
`timescale 1ns/100ps
module seq_monitor
    import exc_pkg::*;
(
    input wire logic             i_clk,                    // Clock.
    input wire logic             i_reset,                  // Reset.
    input wire logic             i_exc_req,                // Start.
    input wire cause_t           i_exc_cause,              // Cause.
    input wire logic [2:0]       i_interrupt_level_inputs, // Level.
    input wire logic [15:0]      i_status_word,            // Status in.
    input wire logic             i_bus_ack,                // Ack.
    input wire logic             i_bus_err,                // Error.
    input wire logic             i_bus_autovector,         // Auto.
    input wire bus_cmd_t         o_bus,                    // Bus cycle.
    input wire logic             o_busy,                   // Busy.
    input wire logic             o_done,                   // Done.
    input wire logic [15:0]      o_status_word,            // Status out.
    input wire logic [15:0]      o_saved_status_word,      // Copy.
    input wire logic [VEC_W-1:0] o_vector_num              // Vector.
);
    logic rd;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // A vector read is any read outside the acknowledge space.
    assign rd = o_bus.req && !o_bus.write && o_bus.space != cpu_space;

    // Entry updates of the status word.
    chk_copy_status: assert property (
        !o_busy && i_exc_req |=> o_saved_status_word == $past(i_status_word))
        else $error("saved status word wrong");
    chk_int_mask: assert property (
        !o_busy && i_exc_req && i_exc_cause == cause_interrupt |=>
        o_status_word[STAT_MASK_HI:STAT_MASK_LO] ==
        $past(i_interrupt_level_inputs))
        else $error("interrupt mask not updated");
    chk_super_mode: assert property (
        o_done |-> o_status_word[STAT_SUPER_BIT] &&
        !o_status_word[STAT_TRACE_BIT])
        else $error("handler not in supervisor state");
    // Bus cycles issued while sequencing.
    chk_iack_cycle: assert property (
        o_bus.req && o_bus.space == cpu_space |->
        !o_bus.write && o_bus.addr[ADDR_W-1:4] == IACK_ADDR_HI)
        else $error("acknowledge cycle malformed");
    chk_reset_stack: assert property (
        o_bus.req && o_bus.write |->
        o_bus.space == supervisor_data_space && o_vector_num != VEC_RESET)
        else $error("stack write in wrong case");
    chk_vec_space: assert property (
        rd |-> o_bus.space == (o_vector_num == VEC_RESET ?
        supervisor_program_space : supervisor_data_space))
        else $error("vector read in wrong space");
    chk_vec_addr: assert property (
        rd && o_vector_num != VEC_RESET |->
        o_bus.addr == {14'h0, o_vector_num, 2'h0} ||
        o_bus.addr == {14'h0, o_vector_num, 2'h2})
        else $error("vector address wrong");
    chk_reset_words: assert property (
        rd && o_vector_num == VEC_RESET |->
        o_bus.addr[ADDR_W-1:3] == 21'h0 && !o_bus.addr[0])
        else $error("reset vector read out of range");
    chk_bus_hold: assert property (
        o_bus.req && !i_bus_ack && !i_bus_err |=> $stable(o_bus))
        else $error("bus request changed before answer");
    // Vector choice after the acknowledge cycle, and the single done pulse.
    chk_spurious: assert property (
        o_bus.req && o_bus.space == cpu_space && i_bus_err |->
        ##[1:2] o_vector_num == VEC_SPURIOUS)
        else $error("spurious vector not taken");
    chk_autovector: assert property (
        o_bus.req && o_bus.space == cpu_space && i_bus_ack && !i_bus_err &&
        i_bus_autovector |-> ##[1:2] o_vector_num ==
        VEC_AUTO_BASE + {5'h0, o_status_word[STAT_MASK_HI:STAT_MASK_LO]})
        else $error("autovector wrong");
    chk_done_once: assert property (
        o_done |-> !o_busy ##1 !o_done)
        else $error("done not a single pulse");

    // Main scenarios reached.
    cover property (o_done && o_vector_num == VEC_RESET);
    cover property (o_done && o_vector_num == VEC_SPURIOUS);
    cover property (o_bus.req && o_bus.write && i_bus_ack);
endmodule

bind exception_vector_sequencer seq_monitor i_mon (
    .i_clk, .i_reset, .i_exc_req, .i_exc_cause, .i_interrupt_level_inputs,
    .i_status_word, .i_bus_ack, .i_bus_err, .i_bus_autovector, .o_bus,
    .o_busy, .o_done, .o_status_word, .o_saved_status_word, .o_vector_num
);

// *** testbench/bus_model.sv ***
// Memory and interrupting peripheral model on the sequencer bus.
`timescale 1ns/100ps
module bus_model
    import exc_pkg::*;
(
    input  wire logic       i_clk,       // Clock.
    input  wire bus_cmd_t   i_bus,       // Request from the sequencer.
    input  wire logic [1:0] i_iack_mode, // 0 vector, 1 auto, 2 error.
    input  wire logic [7:0] i_iack_vec,  // Vector to hand back.
    input  wire logic [3:0] i_wait,      // Wait cycles per cycle.
    output logic            o_ack,       // Cycle done.
    output logic            o_err,       // Bus error.
    output logic            o_auto,      // Autovector request.
    output logic [15:0]     o_rdata      // Read data.
);
    logic [15:0] stk [logic [23:0]];
    logic [3:0]  cnt;
    logic        iack;
    logic [15:0] word;

    // Table words carry their own address so every fetch is traceable.
    assign iack = i_bus.space == cpu_space;
    assign word = iack ? {8'h00, i_iack_vec}
                       : {4'h5, i_bus.addr[11:0]};

    initial begin
        o_ack = 1'b0;
        o_err = 1'b0;
        o_auto = 1'b0;
        o_rdata = 16'h0;
        cnt = 4'h0;
    end

    // Answers after the wait count; idle data toggles so it is never stale.
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_err <= 1'b0;
        o_auto <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_bus.req && !o_ack && !o_err) begin
            if (cnt < i_wait) begin
                cnt <= cnt + 4'h1;
            end else begin
                cnt <= 4'h0;
                o_rdata <= word;
                o_err <= iack && i_iack_mode == 2'h2;
                o_ack <= !(iack && i_iack_mode == 2'h2);
                o_auto <= iack && i_iack_mode == 2'h1;
                if (i_bus.write) begin
                    stk[i_bus.addr] = i_bus.wdata;
                end
            end
        end
    end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the exception vector sequencer.
`timescale 1ns/100ps
module testbench
    import exc_pkg::*;
;
    logic        i_clk;
    logic        i_reset  = 1'b1;
    logic        req      = 1'b0;
    cause_t      cause    = cause_reset;
    logic [15:0] opcode   = 16'h0;
    logic [3:0]  trap     = 4'h0;
    logic [2:0]  level    = 3'h0;
    logic [15:0] sw       = 16'h801f;
    logic [31:0] pc       = 32'h0001_0000;
    logic [31:0] stk_top  = 32'h0000_8000;
    logic [1:0]  mode     = 2'h0;
    logic [7:0]  ivec     = 8'h40;
    logic [3:0]  wt       = 4'h0;
    logic        ack;
    logic        err;
    logic        auto;
    logic [15:0] rdata;
    bus_cmd_t    bus;
    logic        busy;
    logic        done;
    logic [31:0] new_pc;
    logic [31:0] new_sp;
    logic [15:0] new_sw;
    logic [15:0] saved_sw;
    logic [7:0]  vec;
    int          bad_count = 0;
    int          check_count = 0;

    exception_vector_sequencer i_dut (
        .i_clk, .i_reset, .i_exc_req(req), .i_exc_cause(cause),
        .i_opcode(opcode), .i_trap_num(trap), .i_interrupt_level_inputs(level),
        .i_status_word(sw), .i_pc(pc), .i_supervisor_stack_pointer(stk_top),
        .i_bus_ack(ack), .i_bus_err(err), .i_bus_autovector(auto),
        .i_bus_rdata(rdata), .o_bus(bus), .o_busy(busy), .o_done(done),
        .o_pc(new_pc), .o_supervisor_stack_pointer(new_sp),
        .o_status_word(new_sw), .o_saved_status_word(saved_sw),
        .o_vector_num(vec));
    bus_model i_bm (
        .i_clk, .i_bus(bus), .i_iack_mode(mode), .i_iack_vec(ivec),
        .i_wait(wt), .o_ack(ack), .o_err(err), .o_auto(auto), .o_rdata(rdata));

    // Clock of 100 ns period.
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Waits a bounded time for the end-of-sequence pulse.
    task automatic wait_done();
        int n;
        for (n = 0; n < 400 && done !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
        if (done !== 1'b1) begin
            bad_count++;
            results();
        end
    endtask

    // Handler address that the model's table holds for a vector.
    function automatic logic [31:0] handler(input logic [7:0] v);
        logic [11:0] a;
        a = {2'h0, v, 2'h0};
        return {4'h5, a, 4'h5, a + 12'h2};
    endfunction

    // One exception entry; checks state, stack frame and handler address.
    task automatic run(input cause_t c, input logic [7:0] ev,
                       input logic [2:0] lv = 3'h0,
                       input logic [15:0] op = 16'h0,
                       input logic [3:0] n = 4'h0);
        logic [15:0] es;
        @(negedge i_clk);
        cause = c;
        level = lv;
        opcode = op;
        trap = n;
        stk_top = stk_top - 32'h40;
        pc = pc + 32'h0102_0304;
        req = 1'b1;
        @(negedge i_clk);
        req = 1'b0;
        wait_done();
        es = (sw & 16'h7fff) | 16'h2000;
        if (c == cause_interrupt) begin
            es[10:8] = lv;
        end
        chk("vector", {24'h0, ev}, {24'h0, vec});
        chk("handler", handler(ev), new_pc);
        chk("status", {16'h0, es}, {16'h0, new_sw});
        chk("saved", {16'h0, sw}, {16'h0, saved_sw});
        chk("stack", stk_top - 32'h6, new_sp);
        chk("pc lo", {16'h0, pc[15:0]},
            {16'h0, i_bm.stk[stk_top[23:0]-24'h2]});
        chk("pc hi", {16'h0, pc[31:16]},
            {16'h0, i_bm.stk[stk_top[23:0]-24'h4]});
        chk("frame sw", {16'h0, sw},
            {16'h0, i_bm.stk[stk_top[23:0]-24'h6]});
    endtask

    // Reset held 16 cycles, then the four-word reset vector is loaded.
    task automatic t_reset();
        @(negedge i_clk);
        i_reset = 1'b1;
        repeat (16) @(negedge i_clk);
        i_reset = 1'b0;
        wait_done();
        chk("reset vector", 32'h0, {24'h0, vec});
        chk("reset pc", 32'h5004_5006, new_pc);
        chk("reset sp", 32'h5000_5002, new_sp);
        chk("reset status", 32'h2700, {16'h0, new_sw});
    endtask

    // Every internally numbered cause but reset, including both trap operand ends.
    task automatic t_internal();
        run(cause_bus_error, 8'h02);
        run(cause_address_error, 8'h03);
        run(cause_illegal_opcode, 8'h04, 3'h0, 16'h4afc);
        run(cause_divide_zero, 8'h05);
        run(cause_bound_check_instruction, 8'h06);
        run(cause_overflow_trap_instruction, 8'h07);
        run(cause_privilege, 8'h08);
        run(cause_trace, 8'h09);
        run(cause_illegal_opcode, 8'h0a, 3'h0, 16'ha123);
        run(cause_illegal_opcode, 8'h0b, 3'h0, 16'hf001);
        run(cause_trap, 8'h20, 3'h0, 16'h0, 4'h0);
        run(cause_trap, 8'h2f, 3'h0, 16'h0, 4'hf);
    endtask

    // Interrupts: slow peripheral vectors, autovectors and a bus error.
    task automatic t_interrupt();
        wt = 4'h3;
        run(cause_interrupt, 8'h40, 3'h5);
        ivec = 8'hff;
        run(cause_interrupt, 8'hff, 3'h3);
        ivec = 8'h0f;
        run(cause_interrupt, 8'h0f, 3'h2);
        wt = 4'h0;
        mode = 2'h1;
        run(cause_interrupt, 8'h19, 3'h1);
        run(cause_interrupt, 8'h1f, 3'h7);
        mode = 2'h2;
        ivec = 8'h44;
        run(cause_interrupt, 8'h18, 3'h4);
    endtask

    // A reset arriving in mid-sequence restarts from the reset vector.
    task automatic t_abort();
        @(negedge i_clk);
        cause = cause_trap;
        req = 1'b1;
        @(negedge i_clk);
        req = 1'b0;
        repeat (3) @(negedge i_clk);
        t_reset();
    endtask

    // Main sequence.
    initial begin
        t_reset();
        t_internal();
        t_interrupt();
        t_abort();
        results();
    end
endmodule
